//--- sprc_pkg.sv
// package: register map, field layout and timing constants of the reset control
package sprc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 32;
    localparam int          DATA_W        = 32;
    localparam logic [31:0] RST_CTRL_ADDR = 32'hD0030018;
    localparam logic [31:0] RST_CTRL_INIT = 32'h00000000;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int          CHIP_BIT      = 31;
    localparam int          EBI_BIT       = 20;
    localparam logic [31:0] PULSE_MASK    = 32'h80100000;
    localparam logic [31:0] LEVEL_MASK    = 32'h7FEFFFFF;
    localparam int          NUM_PERIPH    = 30;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          PULSE_NS      = 640;
    localparam int          PULSE_CYCLES  =
        (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sprc_req_t;

    typedef enum logic [0:0] {
        SPRC_IDLE  = 1'b0,
        SPRC_PULSE = 1'b1
    } sprc_state_t;

endpackage

//--- sprc_pulse.sv
// module: fixed-length reset pulse generator
`timescale 1ns/1ps
`default_nettype none

module sprc_pulse #(
    parameter int LEN = 16
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic fire_in,
    output var  logic pulse_out
);

    localparam int CW = $clog2(LEN + 1);

    if (LEN < 1) begin : g_len_check
        $error("pulse length must be at least one cycle");
    end

    sprc_pkg::sprc_state_t state;
    sprc_pkg::sprc_state_t next_state;
    logic [CW-1:0]         count;
    logic [CW-1:0]         next_count;

    // a fire during a pulse restarts the full length
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            sprc_pkg::SPRC_IDLE: begin
                if (fire_in) begin
                    next_state = sprc_pkg::SPRC_PULSE;
                    next_count = CW'(LEN - 1);
                end
            end
            sprc_pkg::SPRC_PULSE: begin
                if (fire_in) begin
                    next_count = CW'(LEN - 1);
                end else if (count == '0) begin
                    next_state = sprc_pkg::SPRC_IDLE;
                end else begin
                    next_count = count - 1'b1;
                end
            end
            default: begin
                next_state = sprc_pkg::SPRC_IDLE;
                next_count = '0;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= sprc_pkg::SPRC_IDLE;
            count <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign pulse_out = (state == sprc_pkg::SPRC_PULSE);

endmodule

`default_nettype wire

//--- sprc_top.sv
// module: software peripheral reset control register and reset outputs
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - writing one to bit 31 pulses the global chip reset
// - bits 31 and 20 self-clear and always read back zero
// - writing one to bit 20 pulses only the external bus interface reset
// - bits 30..21 and 19..0 hold their peripheral in reset until cleared
// - software sets and clears peripheral resets; chip and bus block pulsed
// - one write may reset any combination of peripherals at once
module sprc_top #(
    parameter int PULSE_LEN = sprc_pkg::PULSE_CYCLES
) (
    // clock and reset
    input  wire logic        REF_CLK_IN,
    input  wire logic        RESET_IN,
    // register port
    input  wire logic [31:0] ADDR_IN,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output var  logic [31:0] RDATA_OUT,
    // reset outputs
    output var  logic [29:0] PERIPH_RST_OUT,
    output var  logic        EBI_RST_OUT,
    output var  logic        CHIP_RST_OUT
);

    // refuse a pulse length the counters cannot serve
    if (PULSE_LEN < 1) begin : g_len_check
        $error("PULSE_LEN must be at least one");
    end

    // ------------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------------
    sprc_pkg::sprc_req_t req;
    logic                hit;
    logic                wr_hit;

    assign req.wr    = WR_IN;
    assign req.rd    = RD_IN;
    assign req.addr  = ADDR_IN;
    assign req.wdata = WDATA_IN;
    assign hit       = (req.addr == sprc_pkg::RST_CTRL_ADDR);
    assign wr_hit    = req.wr && hit;

    // ------------------------------------------------------------------
    // level reset bits
    // ------------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [31:0] next_rdata;

    always_comb begin
        next_ctrl = ctrl;
        if (wr_hit) begin
            next_ctrl = req.wdata & sprc_pkg::LEVEL_MASK;
        end
        next_rdata = '0;
        if (req.rd && hit) begin
            next_rdata = ctrl & sprc_pkg::LEVEL_MASK;
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ctrl      <= sprc_pkg::RST_CTRL_INIT;
            RDATA_OUT <= '0;
        end else begin
            ctrl      <= next_ctrl;
            RDATA_OUT <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // reset outputs, registered
    // ------------------------------------------------------------------
    logic [29:0] next_periph;
    logic        ebi_pulse;
    logic        chip_pulse;

    always_comb begin
        next_periph = {ctrl[30:21], ctrl[19:0]};
    end

    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            PERIPH_RST_OUT <= '0;
            EBI_RST_OUT    <= 1'b0;
            CHIP_RST_OUT   <= 1'b0;
        end else begin
            PERIPH_RST_OUT <= next_periph;
            EBI_RST_OUT    <= ebi_pulse;
            CHIP_RST_OUT   <= chip_pulse;
        end
    end

    // ------------------------------------------------------------------
    // pulse generators
    // ------------------------------------------------------------------
    sprc_pulse #(
        .LEN       (PULSE_LEN)
    ) u_ebi (
        .clk_in    (REF_CLK_IN),
        .rst_in    (RESET_IN),
        .fire_in   (wr_hit && req.wdata[sprc_pkg::EBI_BIT]),
        .pulse_out (ebi_pulse)
    );

    sprc_pulse #(
        .LEN       (PULSE_LEN)
    ) u_chip (
        .clk_in    (REF_CLK_IN),
        .rst_in    (RESET_IN),
        .fire_in   (wr_hit && req.wdata[sprc_pkg::CHIP_BIT]),
        .pulse_out (chip_pulse)
    );

endmodule

`default_nettype wire

//--- sprc_top_monitor.sv
// checker: reset control register and reset pulse assertions
`timescale 1ns/1ps
`default_nettype none
module sprc_mon #(parameter int PULSE_LEN = 16) (
    // clock and reset
    input wire logic        REF_CLK_IN,
    input wire logic        RESET_IN,
    // register port
    input wire logic [31:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic        WR_IN,
    input wire logic        RD_IN,
    input wire logic [31:0] RDATA_OUT,
    // reset outputs
    input wire logic [29:0] PERIPH_RST_OUT,
    input wire logic        EBI_RST_OUT,
    input wire logic        CHIP_RST_OUT
);
    logic       hit;
    logic [7:0] len;
    assign hit = WR_IN && ADDR_IN == sprc_pkg::RST_CTRL_ADDR;
    // cycles the bus block reset has been high so far
    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) len <= 8'h00;
        else len <= EBI_RST_OUT ? len + 8'h01 : 8'h00;
    end
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (RESET_IN);
    sequence fire(b);
        hit && b;
    endsequence
    chip_pulse_a:
    assert property (fire(WDATA_IN[31]) |=> ##1 CHIP_RST_OUT)
        else $error("chip pulse missing");
    read_zero_a:
    assert property ((RDATA_OUT & sprc_pkg::PULSE_MASK) == 32'h0)
        else $error("pulse bit read as one");
    ebi_only_a:
    assert property (fire(WDATA_IN[20] && !WDATA_IN[31])
        |=> ##1 EBI_RST_OUT && !CHIP_RST_OUT) else $error("ebi pulse wrong");
    level_hold_a:
    assert property (hit |=> ##1 PERIPH_RST_OUT ==
        {$past(WDATA_IN[30:21], 2), $past(WDATA_IN[19:0], 2)})
        else $error("level reset wrong");
    sw_only_a:
    assert property ($changed(PERIPH_RST_OUT) |-> $past(hit, 2))
        else $error("level reset moved alone");
    all_at_once_a:
    assert property (fire((WDATA_IN & sprc_pkg::LEVEL_MASK) ==
        sprc_pkg::LEVEL_MASK) |=> ##1 &PERIPH_RST_OUT)
        else $error("not all in reset");
    pulse_len_a:
    assert property ($fell(EBI_RST_OUT) |-> len == PULSE_LEN)
        else $error("ebi pulse length wrong");
endmodule
bind sprc_top sprc_mon #(.PULSE_LEN(PULSE_LEN)) u_mon (
    .REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .PERIPH_RST_OUT(PERIPH_RST_OUT), .EBI_RST_OUT(EBI_RST_OUT),
    .CHIP_RST_OUT(CHIP_RST_OUT));
`default_nettype wire

//--- sprc_top_bench.sv
// testbench: reset control register against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module sprc_top_bench;
    localparam int          PL = 3;
    localparam logic [31:0] A  = sprc_pkg::RST_CTRL_ADDR;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ebi, chip;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, m = 32'h0, d;
    logic [29:0] prst;
    int          n_mismatch = 0, comparisons = 0, seed = 26940, n, k;
    always #20 clk = ~clk;
    sprc_top #(.PULSE_LEN(PL)) u_dut (.REF_CLK_IN(clk), .RESET_IN(rst),
        .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .PERIPH_RST_OUT(prst), .EBI_RST_OUT(ebi),
        .CHIP_RST_OUT(chip));
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wt(logic [31:0] a, logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        if (a == A) m = v & sprc_pkg::LEVEL_MASK;
    endtask
    task automatic rdk(logic [31:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, a == A ? m : 32'h0);
    endtask
    task automatic lvl();
        @(posedge clk);
        #1;
        chk("periph", {2'h0, prst}, {2'h0, m[30:21], m[19:0]});
    endtask
    task automatic pulse(logic [31:0] v);
        wt(A, v | m);
        n = 0;
        k = 0;
        repeat (PL + 4) begin
            @(posedge clk);
            #1;
            n += (ebi === 1'b1);
            k += (chip === 1'b1);
        end
        chk("ebi len", n, v[20] ? PL : 0);
        chk("chip len", k, v[31] ? PL : 0);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdk(A);
        lvl();
        $display("test reset done");
        repeat (6) begin
            d = $random(seed);
            wt(A, d);
            lvl();
            rdk(A);
        end
        wt(A, 32'hFFFFFFFF);
        lvl();
        wt(A, 32'h0);
        lvl();
        $display("test levels done");
        wt(A, 32'h2A0A55A5);
        for (int i = 0; i < 3; i++) begin
            d = {i != 1, 10'h000, i != 0, 20'h00000};
            pulse(d);
            lvl();
            rdk(A);
        end
        wt(32'hD003001C, 32'hFFFFFFFF);
        lvl();
        rdk(32'hD003001C);
        $display("test pulses and unmapped done");
        print_verdict();
    end
endmodule
`default_nettype wire
